/* File: pkg/spi_cfg_pkg.sv */
`default_nettype none
package spi_cfg_pkg;
  localparam logic [3:0] CTRL_ONE_OFFSET = 4'h0;
  localparam logic [3:0] CTRL_TWO_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;
  localparam logic [3:0] XFER_OFFSET = 4'hc;
  // control one field positions
  localparam int CKE_BIT = 8;
  localparam int SAMPLE_PHASE_BIT = 9;
  localparam int SLAVE_SELECT_BIT = 7;
  localparam int POLARITY_BIT = 6;
  localparam int MASTER_BIT = 5;
  localparam logic [15:0] CTRL_ONE_MASK = 16'h03ff;
  // control two field positions
  localparam int FRAMED_BIT = 15;
  localparam int FSDIR_BIT = 14;
  localparam int FSPOL_BIT = 13;
  localparam int FSEDGE_BIT = 1;
  localparam logic [15:0] CTRL_TWO_MASK = 16'he002;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [4:0] FRAME_BITS = 5'h08;

  typedef struct packed {
    logic master_enable;
    logic input_sample_phase;
    logic clock_edge;
    logic clock_polarity_select;
    logic slave_select_enable;
    logic framed_enable;
    logic frame_sync_direction;
    logic frame_sync_polarity;
    logic frame_sync_edge;
    logic [2:0] secondary_prescale;
    logic [1:0] primary_prescale;
  } spi_cfg_s;

  typedef struct packed {
    logic sck;
    logic sdo;
    logic fsync;
    logic fsync_oe_n;
  } spi_pins_s;
endpackage : spi_cfg_pkg
`default_nettype wire

/* File: rtl/spi_clk_div.sv */
`default_nettype none
// master clock divider: one-cycle tick at sys_clk / (primary * secondary)
module spi_clk_div (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [1:0] primary_i,
  input wire logic [2:0] secondary_i,
  output logic tick_o
);
  logic [5:0] pri_cnt_reg;
  logic [2:0] sec_cnt_reg;
  logic [5:0] pri_max;
  logic [2:0] sec_max;
  logic pri_tick;

  // primary terminal count per code
  always_comb
  begin
    case (primary_i)
      2'b11: pri_max = 6'h00;
      2'b10: pri_max = 6'h03;
      2'b01: pri_max = 6'h0f;
      default: pri_max = 6'h3f;
    endcase
    sec_max = 3'h7 - secondary_i;
  end

  assign pri_tick = run_i && (pri_cnt_reg >= pri_max);

  // primary stage; restarts when idle so first bit has full length
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !run_i || pri_tick)
      pri_cnt_reg <= 6'h00;
    else
      pri_cnt_reg <= pri_cnt_reg + 6'h01;
  end

  // secondary stage counts primary ticks
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !run_i)
      sec_cnt_reg <= 3'h0;
    else if (pri_tick)
      sec_cnt_reg <= (sec_cnt_reg >= sec_max) ? 3'h0 : sec_cnt_reg + 3'h1;
  end

  assign tick_o = pri_tick && (sec_cnt_reg >= sec_max);
endmodule : spi_clk_div
`default_nettype wire

/* File: rtl/spi_clock_mode_config.sv */
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`default_nettype none
// register block and master-side serial clock/frame generation
module spi_clock_mode_config (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic sdi_i,
  output logic sck_o,
  output logic sdo_o,
  output logic fsync_o,
  output logic fsync_oe_n_o,
  output logic [7:0] rx_data_o
);
  logic [15:0] ctrl_one_reg;
  logic [15:0] ctrl_two_reg;
  spi_cfg_pkg::spi_cfg_s cfg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic [4:0] half_cnt_reg;
  logic busy_reg;
  logic start_req;
  logic tick;
  logic sck_reg;
  logic sdo_reg;
  logic fs_reg;
  logic sdi_meta_reg;
  logic sdi_sync_reg;
  logic late_sample_reg;
  logic done_reg;
  logic [15:0] rd_word;

  // merge written bytes into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] val;
    val = old;
    if (strb[0])
      val[7:0] = data[7:0];
    if (strb[1])
      val[15:8] = data[15:8];
    return val & mask;
  endfunction : merge16

  // slave mode keeps sample phase clear even within the write that selects it
  function automatic logic [15:0] lock_phase(input logic [15:0] val);
    logic [15:0] res;
    res = val;
    if (!val[spi_cfg_pkg::MASTER_BIT])
      res[spi_cfg_pkg::SAMPLE_PHASE_BIT] = 1'b0;
    return res;
  endfunction : lock_phase

  // unpack control registers; effective bits applied here
  always_comb
  begin
    cfg.master_enable = ctrl_one_reg[spi_cfg_pkg::MASTER_BIT];
    cfg.input_sample_phase = ctrl_one_reg[spi_cfg_pkg::SAMPLE_PHASE_BIT] &&
                             cfg.master_enable;
    cfg.framed_enable = ctrl_two_reg[spi_cfg_pkg::FRAMED_BIT];
    cfg.clock_edge = ctrl_one_reg[spi_cfg_pkg::CKE_BIT] && !cfg.framed_enable;
    cfg.clock_polarity_select = ctrl_one_reg[spi_cfg_pkg::POLARITY_BIT];
    cfg.slave_select_enable = ctrl_one_reg[spi_cfg_pkg::SLAVE_SELECT_BIT];
    cfg.frame_sync_direction = ctrl_two_reg[spi_cfg_pkg::FSDIR_BIT];
    cfg.frame_sync_polarity = ctrl_two_reg[spi_cfg_pkg::FSPOL_BIT];
    cfg.frame_sync_edge = ctrl_two_reg[spi_cfg_pkg::FSEDGE_BIT];
    cfg.secondary_prescale = ctrl_one_reg[4:2];
    cfg.primary_prescale = ctrl_one_reg[1:0];
  end

  // write address and data are taken independently, in either order
  assign awready = !aw_held_reg && !bvalid;
  assign wready = !w_held_reg && !bvalid;
  assign do_write = aw_held_reg && w_held_reg && !bvalid;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
    end
    else if (awvalid && awready)
    begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end
    else if (do_write)
      aw_held_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      w_held_reg <= 1'b1;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end
    else if (do_write)
      w_held_reg <= 1'b0;
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      bvalid <= 1'b0;
      bresp <= spi_cfg_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp <= (aw_addr_reg == spi_cfg_pkg::CTRL_ONE_OFFSET ||
                aw_addr_reg == spi_cfg_pkg::CTRL_TWO_OFFSET ||
                aw_addr_reg == spi_cfg_pkg::XFER_OFFSET) ?
               spi_cfg_pkg::RESP_OKAY : spi_cfg_pkg::RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // control one; sample phase cannot be set while slave
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      ctrl_one_reg <= spi_cfg_pkg::CTRL_RESET;
    else if (do_write && aw_addr_reg == spi_cfg_pkg::CTRL_ONE_OFFSET)
      ctrl_one_reg <= lock_phase(merge16(ctrl_one_reg, w_data_reg, w_strb_reg,
                                         spi_cfg_pkg::CTRL_ONE_MASK));
  end

  // control two
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      ctrl_two_reg <= spi_cfg_pkg::CTRL_RESET;
    else if (do_write && aw_addr_reg == spi_cfg_pkg::CTRL_TWO_OFFSET)
      ctrl_two_reg <= merge16(ctrl_two_reg, w_data_reg, w_strb_reg,
                              spi_cfg_pkg::CTRL_TWO_MASK);
  end

  // read mux; stored sample phase is already clear in slave mode
  always_comb
  begin
    case (araddr)
      spi_cfg_pkg::CTRL_ONE_OFFSET: rd_word = ctrl_one_reg;
      spi_cfg_pkg::CTRL_TWO_OFFSET: rd_word = ctrl_two_reg;
      spi_cfg_pkg::STATUS_OFFSET: rd_word = {15'h0000, busy_reg};
      spi_cfg_pkg::XFER_OFFSET: rd_word = {8'h00, rx_reg};
      default: rd_word = 16'h0000;
    endcase
  end

  assign arready = !rvalid;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= spi_cfg_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata <= {16'h0000, rd_word};
      rresp <= (araddr[1:0] == 2'b00) ? spi_cfg_pkg::RESP_OKAY : spi_cfg_pkg::RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // a write to the transfer word starts a master frame
  assign start_req = do_write && aw_addr_reg == spi_cfg_pkg::XFER_OFFSET &&
                     cfg.master_enable && !busy_reg;

  spi_clk_div u_div (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .run_i(busy_reg),
    .primary_i(cfg.primary_prescale),
    .secondary_i(cfg.secondary_prescale),
    .tick_o(tick)
  );

  // serial input crosses from the pin
  always_ff @(posedge sys_clk_i)
  begin
    sdi_meta_reg <= sdi_i;
    sdi_sync_reg <= sdi_meta_reg;
  end

  // frame sequencer: two ticks per bit, plus one lead bit when sync precedes
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      busy_reg <= 1'b0;
      half_cnt_reg <= 5'h00;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      sck_reg <= 1'b0;
      sdo_reg <= 1'b0;
      fs_reg <= 1'b0;
      late_sample_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else if (start_req)
    begin
      busy_reg <= 1'b1;
      tx_reg <= w_data_reg[7:0];
      sdo_reg <= cfg.clock_edge ? 1'b0 : w_data_reg[7];
      // edge one: sync with first bit clock; zero: one bit ahead
      half_cnt_reg <= (cfg.framed_enable && !cfg.frame_sync_edge) ? 5'h12 : 5'h10;
      fs_reg <= cfg.framed_enable;
      sck_reg <= cfg.clock_polarity_select;
      done_reg <= 1'b0;
    end
    else if (busy_reg && tick)
    begin
      half_cnt_reg <= half_cnt_reg - 5'h01;
      if (half_cnt_reg > 5'h10)
      begin
        // lead bit: sync asserted, clock held idle
        if (half_cnt_reg == 5'h11)
          fs_reg <= 1'b0;
      end
      else if (half_cnt_reg == 5'h00)
      begin
        // the last trailing edge already took the eighth late sample
        busy_reg <= 1'b0;
        done_reg <= 1'b1;
        late_sample_reg <= 1'b0;
        sck_reg <= cfg.clock_polarity_select;
      end
      else
      begin
        sck_reg <= ~sck_reg;
        if (half_cnt_reg == 5'h10)
          fs_reg <= 1'b0;
        if (half_cnt_reg[0] == 1'b0)
        begin
          // leading edge of bit: sample now or at end of bit
          if (cfg.input_sample_phase)
            late_sample_reg <= 1'b1;
          else
            rx_reg <= {rx_reg[6:0], sdi_sync_reg};
          if (cfg.clock_edge)
          begin
            sdo_reg <= tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
          end
        end
        else
        begin
          // trailing edge of bit
          if (late_sample_reg)
            rx_reg <= {rx_reg[6:0], sdi_sync_reg};
          if (!cfg.clock_edge)
          begin
            tx_reg <= {tx_reg[6:0], 1'b0};
            sdo_reg <= tx_reg[6];
          end
        end
      end
    end
    else if (!busy_reg)
      sck_reg <= cfg.clock_polarity_select;
  end

  // pins: sync driven only when framed output master
  assign sck_o = sck_reg;
  assign sdo_o = sdo_reg;
  assign fsync_o = fs_reg ~^ cfg.frame_sync_polarity;
  assign fsync_oe_n_o = !(cfg.master_enable && cfg.framed_enable &&
                          !cfg.frame_sync_direction);
  assign rx_data_o = rx_reg;
endmodule : spi_clock_mode_config
`default_nettype wire

/* File: bench/spi_slave_model.sv */
`default_nettype none
// far-side slave: one fixed level per frame, or echo of the device's output
module spi_slave_model (
  input wire logic en_i,
  input wire logic loop_i,
  input wire logic fill_i,
  input wire logic sdo_i,
  output logic sdi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // released line shows the inverse, so stale data cannot pass as received;
  // echo needs slow bit clocks, it passes the device's input synchroniser
  assign sdi_o = !en_i ? ~fill_i : (loop_i ? sdo_i : fill_i);
endmodule : spi_slave_model
`default_nettype wire

/* File: bench/spi_cfg_checker.sv */
`default_nettype none
module spi_cfg_checker (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic sck_o,
  input wire logic fsync_oe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ar_q;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // remember which register the pending read answers for
  always_ff @(posedge sys_clk_i)
  begin
    if (arvalid && arready)
      ar_q <= araddr;
  end
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence ok_read(logic [3:0] a);
    rvalid && rresp == spi_cfg_pkg::RESP_OKAY && ar_q == a;
  endsequence
  chk_write_answer: assert property (wr_taken |-> ##2 bvalid)
    else $error("write response late");
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  chk_write_refused: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  chk_read_refused: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");
  chk_one_unused: assert property (ok_read(spi_cfg_pkg::CTRL_ONE_OFFSET) |->
    rdata[31:10] == 22'h0) else $error("control one unused bits set");
  chk_two_unused: assert property (ok_read(spi_cfg_pkg::CTRL_TWO_OFFSET) |->
    rdata[31:16] == 16'h0 && rdata[12:2] == 11'h0 && !rdata[0])
    else $error("control two unused bits set");
  chk_phase_slave: assert property (ok_read(spi_cfg_pkg::CTRL_ONE_OFFSET) ##0
    !rdata[spi_cfg_pkg::MASTER_BIT] |-> !rdata[spi_cfg_pkg::SAMPLE_PHASE_BIT])
    else $error("sample phase set in slave mode");
  chk_reset_idle: assert property ($fell(rst_i) |->
    !sck_o && fsync_oe_n_o && !bvalid && !rvalid) else $error("not idle after reset");
endmodule : spi_cfg_checker
bind spi_clock_mode_config spi_cfg_checker spi_cfg_checker_i (.sys_clk_i, .rst_i, .awvalid,
  .awready, .wvalid, .wready, .bvalid, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
  .sck_o, .fsync_oe_n_o);
`default_nettype wire

/* File: bench/spi_clock_mode_config_test.sv */
`default_nettype none
module spi_clock_mode_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i, rst_i, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, sdi_i, sck_o, sdo_o, fsync_o, fsync_oe_n_o, en, fill, lb;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] rx_data_o;
  int errors, compares, d0, d1;

  spi_clock_mode_config spi_clock_mode_config_i (.sys_clk_i, .rst_i, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .sdi_i, .sck_o, .sdo_o, .fsync_o,
    .fsync_oe_n_o, .rx_data_o);
  spi_slave_model spi_slave_model_i (.en_i(en), .loop_i(lb), .fill_i(fill), .sdo_i(sdo_o),
    .sdi_o(sdi_i));

  // 250 mhz system clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task complete_run;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  // address and data offered together, each dropped when taken
  task axi_write(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk_i);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge sys_clk_i);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
        break;
    end
    bready <= 1'b0;
    chk({bvalid, 29'h0, bresp}, 32'h80000000);
  endtask : axi_write

  task axi_read(input logic [3:0] a, output logic [31:0] d);
    int n;
    @(posedge sys_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge sys_clk_i);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
        break;
    end
    d = rdata;
    rready <= 1'b0;
    chk({rvalid, 29'h0, rresp}, 32'h80000000);
  endtask : axi_read

  task rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    axi_read(a, d);
    chk(d, exp);
  endtask : rd_chk

  // reset values, writable masks and the sample phase lock-out
  task t_regs;
    rd_chk(4'h0, 32'h0);
    rd_chk(4'h4, 32'h0);
    axi_write(4'h0, 32'h00000200);
    rd_chk(4'h0, 32'h0);
    axi_write(4'h0, 32'h00000020);
    axi_write(4'h0, 32'h00000220);
    rd_chk(4'h0, 32'h00000220);
    axi_write(4'h0, 32'hffffffff);
    rd_chk(4'h0, 32'h000003ff);
    chk(sck_o, 1'b1);
    axi_write(4'h0, 32'h00000200);
    rd_chk(4'h0, 32'h0);
    chk(sck_o, 1'b0);
    axi_write(4'h4, 32'hffffffff);
    rd_chk(4'h4, 32'h0000e002);
  endtask : t_regs

  // one master frame: tick spacing, frame sync lead and received byte
  // echo mode expects the sent byte back, fixed mode the fill level
  task run_frame(input logic [15:0] c1, input logic [15:0] c2, input logic f, input logic l,
    input int half, output int lead);
    int n, t0, t1, tf;
    logic prev;
    logic [31:0] d;
    logic [7:0] exp;
    exp = l ? 8'ha5 : {8{f}};
    axi_write(4'h4, {16'h0, c2});
    axi_write(4'h0, {16'h0, c1});
    repeat (2) @(posedge sys_clk_i);
    chk(sck_o, c1[6]);
    if (c2[15])
      chk({fsync_oe_n_o, fsync_o}, {1'b0, ~c2[13]});
    en <= 1'b1;
    fill <= f;
    lb <= l;
    t0 = -1;
    t1 = -1;
    tf = -1;
    prev = 1'bx;
    axi_write(4'hc, 32'h000000a5);
    // a pulse already under way at the start is skipped, it would read short
    for (n = 0; n < 4000 && t1 < 0; n++)
    begin
      @(posedge sys_clk_i);
      if (tf < 0 && fsync_o === c2[13])
        tf = n;
      if (t0 < 0 && prev === c1[6] && sck_o !== c1[6])
        t0 = n;
      else if (t0 >= 0 && sck_o === c1[6])
        t1 = n;
      prev = sck_o;
    end
    chk(t1 - t0, half);
    lead = t0 - tf;
    for (n = 0; n < 1000; n++)
    begin
      axi_read(4'h8, d);
      if (d[0] === 1'b0)
        break;
    end
    chk(d[0], 1'b0);
    rd_chk(4'hc, {24'h0, exp});
    chk(rx_data_o, exp);
    chk(sck_o, c1[6]);
    en <= 1'b0;
    lb <= 1'b0;
  endtask : run_frame

  // framed runs keep clock edge select at zero as software should
  task t_frames;
    run_frame(16'h003f, 16'h0000, 1'b1, 1'b0, 1, d0);
    run_frame(16'h003a, 16'h0000, 1'b0, 1'b1, 8, d0);
    run_frame(16'h0021, 16'h0000, 1'b1, 1'b1, 128, d0);
    run_frame(16'h007c, 16'h0000, 1'b0, 1'b1, 64, d0);
    run_frame(16'h023a, 16'h0000, 1'b1, 1'b1, 8, d0);
    run_frame(16'h003a, 16'ha000, 1'b0, 1'b1, 8, d0);
    run_frame(16'h003a, 16'h8002, 1'b1, 1'b1, 8, d1);
    chk(d0 > d1, 1'b1);
    chk(d0 - d1, 16);
  endtask : t_frames

  // hang guard, several times the expected run length
  initial
  begin
    #100000;
    errors++;
    complete_run;
  end

  initial
  begin
    errors = 0;
    compares = 0;
    rst_i = 1'b1;
    awaddr = 4'h0;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hf;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 4'h0;
    arvalid = 1'b0;
    rready = 1'b0;
    en = 1'b0;
    fill = 1'b0;
    lb = 1'b0;
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_frames;
    complete_run;
  end
endmodule : spi_clock_mode_config_test
`default_nettype wire
